/* File: verilog/awg_pkg.sv */
// Package for the atomic write guard: register map, fields, types
package awg_pkg;
	localparam int AWG_LBA_W   = 64;
	localparam int AWG_NLB_W   = 16;
	localparam int AWG_UNIT_W  = 16;
	localparam int AWG_APB_AW  = 8;

	// Register byte offsets
	localparam logic [AWG_APB_AW-1:0] AWG_OFF_CTRL     = 8'h00;
	localparam logic [AWG_APB_AW-1:0] AWG_OFF_CTRL_AU  = 8'h04;
	localparam logic [AWG_APB_AW-1:0] AWG_OFF_NS_AU    = 8'h08;
	localparam logic [AWG_APB_AW-1:0] AWG_OFF_BSIZE    = 8'h0C;
	localparam logic [AWG_APB_AW-1:0] AWG_OFF_BOFF     = 8'h10;
	localparam logic [AWG_APB_AW-1:0] AWG_OFF_SLBA_LO  = 8'h14;
	localparam logic [AWG_APB_AW-1:0] AWG_OFF_SLBA_HI  = 8'h18;
	localparam logic [AWG_APB_AW-1:0] AWG_OFF_CMD      = 8'h1C;
	localparam logic [AWG_APB_AW-1:0] AWG_OFF_STATUS   = 8'h20;
	localparam logic [AWG_APB_AW-1:0] AWG_OFF_PI       = 8'h24;
	localparam logic [AWG_APB_AW-1:0] AWG_OFF_CAU_CTRL_COMPARE_WRITE_ATOMIC_UNIT = 8'h28;

	// CTRL register bits
	localparam int AWG_CTRL_XB_OK   = 0;
	localparam int AWG_CTRL_VWC_SUP = 1;
	localparam int AWG_CTRL_VWC_EN  = 2;
	localparam int AWG_CTRL_PI_FMT  = 3;
	localparam int AWG_CTRL_MD_BIG  = 4;
	localparam int AWG_CTRL_FLUSH   = 5;
	localparam int AWG_CTRL_SHDN    = 6;
	localparam int AWG_CTRL_PFAIL   = 7;

	// CMD register fields
	localparam int AWG_CMD_NLB_LSB  = 0;
	localparam int AWG_CMD_PI_LSB   = 16;
	localparam int AWG_CMD_FUA      = 20;
	localparam int AWG_CMD_WRITE    = 21;
	localparam int AWG_CMD_GO       = 31;

	// Protection info field layout
	localparam int AWG_PI_W         = 4;
	localparam int AWG_PI_ACT_BIT   = 3;
	localparam int AWG_PI_GUARD_BIT = 2;
	localparam int AWG_PI_APP_BIT   = 1;
	localparam int AWG_PI_REF_BIT   = 0;

	localparam logic [31:0] AWG_RESET_WORD = 32'h0000_0000;

	typedef enum logic [3:0] {
		AWG_IDLE  = 4'b0001,
		AWG_CHECK = 4'b0010,
		AWG_TRACK = 4'b0100,
		AWG_DONE  = 4'b1000
	} awg_state_t;

	typedef struct packed {
		logic [AWG_LBA_W-1:0]  slba;
		logic [AWG_NLB_W-1:0]  nlb;
		logic [AWG_LBA_W-1:0]  bsize;
		logic [AWG_LBA_W-1:0]  boff;
	} awg_range_t;

	typedef struct packed {
		logic strip;
		logic insert;
		logic replace;
		logic pass;
		logic chk_guard;
		logic chk_app;
		logic chk_ref;
	} awg_pi_dec_t;
endpackage

/* File: verilog/awg_boundary_check.sv */
// Boundary crossing check: compares boundary indexes of first and last block
`timescale 1ns/1ps
module awg_boundary_check
	import awg_pkg::*;
(
	input  wire awg_range_t           range_in,
	output logic                      crosses
);
	logic [AWG_LBA_W-1:0] last_lba;
	logic [AWG_LBA_W-1:0] first_idx;
	logic [AWG_LBA_W-1:0] last_idx;
	logic                 first_below;
	logic                 last_below;

	always_comb
	begin
		last_lba    = range_in.slba + AWG_LBA_W'(range_in.nlb);
		first_below = range_in.slba < range_in.boff;
		last_below  = last_lba < range_in.boff;
		first_idx   = '0;
		last_idx    = '0;
		crosses     = 1'b0;
		if (range_in.bsize != '0)
		begin
			if (!first_below)
				first_idx = (range_in.slba - range_in.boff) / range_in.bsize + 1'b1;
			if (!last_below)
				last_idx = (last_lba - range_in.boff) / range_in.bsize + 1'b1;
			crosses = first_idx != last_idx;
		end
	end
endmodule

/* File: verilog/awg_guard.sv */
// Atomic write guard and protection info decode with APB registers
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module awg_guard
	import awg_pkg::*;
#(
	parameter int UNIT_W = AWG_UNIT_W
)
(
	input  wire logic                  clock,
	input  wire logic                  nrst,
	input  wire logic                  clk_en,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [AWG_APB_AW-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic                       normal_atomic,
	output logic                       powerfail_atomic,
	output logic                       may_lose_data,
	output awg_pi_dec_t                pi_decode
);
	logic [7:0]        ctrl_reg;
	logic [UNIT_W-1:0] ctrl_normal_atomic_unit_reg;
	logic [UNIT_W-1:0] ctrl_powerfail_atomic_unit_reg;
	logic [UNIT_W-1:0] ctrl_compare_write_atomic_unit_reg;
	logic [UNIT_W-1:0] ns_normal_atomic_unit_reg;
	logic [UNIT_W-1:0] ns_powerfail_atomic_unit_reg;
	logic [UNIT_W-1:0] ns_boundary_size_normal_reg;
	logic [UNIT_W-1:0] ns_boundary_size_powerfail_reg;
	logic [UNIT_W-1:0] ns_boundary_offset_reg;
	logic [AWG_LBA_W-1:0] slba_reg;
	logic [AWG_NLB_W-1:0] nlb_reg;
	logic [AWG_PI_W-1:0]  prot_info_reg;
	logic                 force_media_write_reg;
	logic                 is_write_reg;
	logic                 cfg_err_reg;
	logic                 cross_n_reg;
	logic                 cross_pf_reg;
	logic                 pending_reg;
	awg_state_t           state_reg;
	awg_state_t           state_next;

	logic                 wr_en;
	logic                 rd_en;
	logic                 addr_ok;
	logic                 go;
	logic                 bnd_sup;
	logic                 cross_n;
	logic                 cross_pf;
	logic [AWG_LBA_W-1:0] size_blocks;
	awg_range_t           range_n;
	awg_range_t           range_pf;

	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite && clk_en;
	assign rd_en   = psel && !pwrite;
	assign pslverr = psel && penable && !addr_ok;
	assign go      = wr_en && addr_ok && paddr == AWG_OFF_CMD && pwdata[AWG_CMD_GO];

	always_comb
	begin
		case (paddr)
			AWG_OFF_CTRL, AWG_OFF_CTRL_AU, AWG_OFF_NS_AU, AWG_OFF_BSIZE,
			AWG_OFF_BOFF, AWG_OFF_SLBA_LO, AWG_OFF_SLBA_HI, AWG_OFF_CMD,
			AWG_OFF_STATUS, AWG_OFF_PI, AWG_OFF_CAU_CTRL_COMPARE_WRITE_ATOMIC_UNIT:
				addr_ok = 1'b1;
			default:
				addr_ok = 1'b0;
		endcase
	end

	assign bnd_sup = ns_boundary_size_normal_reg != '0 ||
		ns_boundary_size_powerfail_reg != '0;

	// Configuration registers
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			ctrl_reg                           <= '0;
			ctrl_normal_atomic_unit_reg        <= '0;
			ctrl_powerfail_atomic_unit_reg     <= '0;
			ctrl_compare_write_atomic_unit_reg <= '0;
			ns_normal_atomic_unit_reg          <= '0;
			ns_powerfail_atomic_unit_reg       <= '0;
			ns_boundary_size_normal_reg        <= '0;
			ns_boundary_size_powerfail_reg     <= '0;
			ns_boundary_offset_reg             <= '0;
		end
		else if (wr_en)
		begin
			case (paddr)
				AWG_OFF_CTRL:
					ctrl_reg <= pwdata[7:0];
				AWG_OFF_CTRL_AU:
				begin
					ctrl_normal_atomic_unit_reg    <= pwdata[UNIT_W-1:0];
					ctrl_powerfail_atomic_unit_reg <= pwdata[16 +: UNIT_W];
				end
				AWG_OFF_CAU_CTRL_COMPARE_WRITE_ATOMIC_UNIT:
					ctrl_compare_write_atomic_unit_reg <= pwdata[UNIT_W-1:0];
				AWG_OFF_NS_AU:
				begin
					ns_normal_atomic_unit_reg    <= pwdata[UNIT_W-1:0];
					ns_powerfail_atomic_unit_reg <= pwdata[16 +: UNIT_W];
				end
				AWG_OFF_BSIZE:
				begin
					ns_boundary_size_normal_reg    <= pwdata[UNIT_W-1:0];
					ns_boundary_size_powerfail_reg <= pwdata[16 +: UNIT_W];
				end
				AWG_OFF_BOFF:
					ns_boundary_offset_reg <= pwdata[UNIT_W-1:0];
				default:
					ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// Command capture
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			slba_reg              <= '0;
			nlb_reg               <= '0;
			prot_info_reg         <= '0;
			force_media_write_reg <= 1'b0;
			is_write_reg          <= 1'b0;
		end
		else if (wr_en && paddr == AWG_OFF_SLBA_LO)
			slba_reg[31:0] <= pwdata;
		else if (wr_en && paddr == AWG_OFF_SLBA_HI)
			slba_reg[63:32] <= pwdata;
		else if (go && state_reg == AWG_IDLE)
		begin
			nlb_reg               <= pwdata[AWG_CMD_NLB_LSB +: AWG_NLB_W];
			prot_info_reg         <= pwdata[AWG_CMD_PI_LSB +: AWG_PI_W];
			force_media_write_reg <= pwdata[AWG_CMD_FUA];
			is_write_reg          <= pwdata[AWG_CMD_WRITE];
		end
	end

	always_comb
	begin
		range_n.slba    = slba_reg;
		range_n.nlb     = nlb_reg;
		range_n.bsize   = AWG_LBA_W'(ns_boundary_size_normal_reg);
		range_n.boff    = AWG_LBA_W'(ns_boundary_offset_reg);
		range_pf        = range_n;
		range_pf.bsize  = AWG_LBA_W'(ns_boundary_size_powerfail_reg);
	end

	awg_boundary_check u_chk_normal
	(
		.range_in (range_n),
		.crosses  (cross_n)
	);

	awg_boundary_check u_chk_pfail
	(
		.range_in (range_pf),
		.crosses  (cross_pf)
	);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			AWG_IDLE:
				if (go)
					state_next = AWG_CHECK;
			AWG_CHECK:
				state_next = is_write_reg ? AWG_TRACK : AWG_DONE;
			AWG_TRACK:
				state_next = AWG_DONE;
			AWG_DONE:
				state_next = AWG_IDLE;
			default:
				state_next = AWG_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			state_reg <= AWG_IDLE;
		else if (clk_en)
			state_reg <= state_next;
	end

	// 0's based count: blocks = nlb + 1
	assign size_blocks = AWG_LBA_W'(nlb_reg) + 1'b1;

	// Verdict on the captured command, read or write
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			cross_n_reg      <= 1'b0;
			cross_pf_reg     <= 1'b0;
			normal_atomic    <= 1'b0;
			powerfail_atomic <= 1'b0;
		end
		else if (clk_en && state_reg == AWG_CHECK)
		begin
			cross_n_reg  <= bnd_sup && cross_n;
			cross_pf_reg <= bnd_sup && cross_pf;
			normal_atomic <= !(bnd_sup && cross_n) &&
				size_blocks <= AWG_LBA_W'(ns_normal_atomic_unit_reg) + 1'b1;
			powerfail_atomic <= !(bnd_sup && cross_pf) &&
				size_blocks <= AWG_LBA_W'(ns_powerfail_atomic_unit_reg) + 1'b1;
		end
	end

	// Track completed cached writes at risk
	always_ff @(posedge clock)
	begin
		if (!nrst)
			pending_reg <= 1'b0;
		else if (clk_en)
		begin
			if (state_reg == AWG_TRACK && ctrl_reg[AWG_CTRL_VWC_SUP] &&
				ctrl_reg[AWG_CTRL_VWC_EN] && !force_media_write_reg)
				pending_reg <= 1'b1;
			else if (ctrl_reg[AWG_CTRL_FLUSH] || ctrl_reg[AWG_CTRL_SHDN])
				pending_reg <= 1'b0;
		end
	end

	// Loss only when power drops with cached data unflushed
	assign may_lose_data = pending_reg && ctrl_reg[AWG_CTRL_PFAIL];

	always_comb
	begin
		pi_decode = '0;
		if (ctrl_reg[AWG_CTRL_PI_FMT])
		begin
			pi_decode.strip   = prot_info_reg[AWG_PI_ACT_BIT] &&
				!ctrl_reg[AWG_CTRL_MD_BIG] && !is_write_reg;
			pi_decode.insert  = prot_info_reg[AWG_PI_ACT_BIT] &&
				!ctrl_reg[AWG_CTRL_MD_BIG] && is_write_reg;
			pi_decode.replace = prot_info_reg[AWG_PI_ACT_BIT] &&
				ctrl_reg[AWG_CTRL_MD_BIG] && is_write_reg;
			pi_decode.pass    = !(pi_decode.strip || pi_decode.insert || pi_decode.replace);
			pi_decode.chk_guard = prot_info_reg[AWG_PI_GUARD_BIT];
			pi_decode.chk_app   = prot_info_reg[AWG_PI_APP_BIT];
			pi_decode.chk_ref   = prot_info_reg[AWG_PI_REF_BIT];
		end
	end

	// Read mux
	always_comb
	begin
		prdata = AWG_RESET_WORD;
		if (rd_en)
		begin
			case (paddr)
				AWG_OFF_CTRL:
					prdata[7:0] = ctrl_reg;
				AWG_OFF_CTRL_AU:
					if (ctrl_reg[AWG_CTRL_XB_OK])
						prdata = {ctrl_powerfail_atomic_unit_reg, ctrl_normal_atomic_unit_reg};
				AWG_OFF_CAU_CTRL_COMPARE_WRITE_ATOMIC_UNIT:
					if (ctrl_reg[AWG_CTRL_XB_OK])
						prdata[UNIT_W-1:0] = ctrl_compare_write_atomic_unit_reg;
				AWG_OFF_NS_AU:
					prdata = {ns_powerfail_atomic_unit_reg, ns_normal_atomic_unit_reg};
				AWG_OFF_BSIZE:
					prdata = {ns_boundary_size_powerfail_reg, ns_boundary_size_normal_reg};
				AWG_OFF_BOFF:
					prdata[UNIT_W-1:0] = ns_boundary_offset_reg;
				AWG_OFF_SLBA_LO:
					prdata = slba_reg[31:0];
				AWG_OFF_SLBA_HI:
					prdata = slba_reg[63:32];
				AWG_OFF_CMD:
					prdata = {10'h000, is_write_reg, force_media_write_reg,
						prot_info_reg, nlb_reg};
				AWG_OFF_STATUS:
					prdata = {22'h000000, cfg_err_reg, may_lose_data, pending_reg,
						cross_pf_reg, cross_n_reg, powerfail_atomic, normal_atomic,
						state_reg == AWG_IDLE, 2'h0};
				AWG_OFF_PI:
					prdata[6:0] = pi_decode;
				default:
					prdata = AWG_RESET_WORD;
			endcase
		end
	end

	// Sizes cover units, offset within sizes
	always_ff @(posedge clock)
	begin
		if (!nrst)
			cfg_err_reg <= 1'b0;
		else if (clk_en)
			cfg_err_reg <= bnd_sup && (
				ns_boundary_size_normal_reg < ns_normal_atomic_unit_reg ||
				ns_boundary_size_powerfail_reg < ns_powerfail_atomic_unit_reg ||
				ns_boundary_offset_reg > ns_boundary_size_normal_reg ||
				ns_boundary_offset_reg > ns_boundary_size_powerfail_reg);
	end
endmodule

/* File: dv/awg_guard_chk.sv */
// Port checker for the atomic write guard
`timescale 1ns/1ps
module awg_guard_chk
	import awg_pkg::*;
#(
	parameter int UNIT_W = AWG_UNIT_W
)
(
	input wire logic                  clock,
	input wire logic                  nrst,
	input wire logic                  clk_en,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [AWG_APB_AW-1:0] paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  normal_atomic,
	input wire logic                  powerfail_atomic,
	input wire logic                  may_lose_data,
	input wire awg_pi_dec_t           pi_decode
);
	logic [7:0] ctrl_sh;
	logic       wr_acc;
	logic       go_acc;
	assign wr_acc = psel && penable && pwrite && clk_en;
	assign go_acc = wr_acc && paddr == AWG_OFF_CMD && pwdata[AWG_CMD_GO];
	// Shadow of the control byte so checks need no internal probes
	always_ff @(posedge clock)
	begin
		if (!nrst)
			ctrl_sh <= 8'h00;
		else if (wr_acc && paddr == AWG_OFF_CTRL)
			ctrl_sh <= pwdata[7:0];
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	property p_ready;
		psel && penable |-> pready;
	endproperty
	property p_err_unmapped;
		psel && penable && paddr > AWG_OFF_CAU_CTRL_COMPARE_WRITE_ATOMIC_UNIT |-> pslverr;
	endproperty
	property p_err_mapped;
		psel && penable && paddr <= AWG_OFF_CAU_CTRL_COMPARE_WRITE_ATOMIC_UNIT && paddr[1:0] == 2'h0 |-> !pslverr;
	endproperty
	property p_units_zero;
		psel && !pwrite && !ctrl_sh[AWG_CTRL_XB_OK]
			&& (paddr == AWG_OFF_CTRL_AU || paddr == AWG_OFF_CAU_CTRL_COMPARE_WRITE_ATOMIC_UNIT) |-> prdata == 32'h0;
	endproperty
	property p_pi_ignored;
		!ctrl_sh[AWG_CTRL_PI_FMT] |-> pi_decode == 7'h00;
	endproperty
	property p_pi_size;
		pi_decode.replace || pi_decode.strip || pi_decode.insert
			|-> pi_decode.replace == ctrl_sh[AWG_CTRL_MD_BIG];
	endproperty
	property p_lose_fail;
		may_lose_data |-> ctrl_sh[AWG_CTRL_PFAIL];
	endproperty
	property p_verdict_cause;
		$changed(normal_atomic) || $changed(powerfail_atomic) |-> $past(go_acc, 2);
	endproperty
	property p_freeze;
		!clk_en |=> $stable(normal_atomic) && $stable(powerfail_atomic) && $stable(pi_decode);
	endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped");
	a_err_mapped: assert property (p_err_mapped) else $error("error on mapped address");
	a_units_zero: assert property (p_units_zero) else $error("units nonzero");
	a_pi_ignored: assert property (p_pi_ignored) else $error("pi decode not idle");
	a_pi_size: assert property (p_pi_size) else $error("pi action vs size");
	a_lose_fail: assert property (p_lose_fail) else $error("loss without fail");
	a_verdict_cause: assert property (p_verdict_cause) else $error("verdict moved");
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");
	c_go: cover property (go_acc);
	c_lose: cover property (may_lose_data);
	c_replace: cover property (pi_decode.replace);
endmodule

bind awg_guard awg_guard_chk #(.UNIT_W(UNIT_W)) u_chk (.clock, .nrst, .clk_en, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .normal_atomic,
	.powerfail_atomic, .may_lose_data, .pi_decode);

/* File: dv/awg_host.sv */
// Host model: APB master issuing register transfers
`timescale 1ns/1ps
module awg_host
	import awg_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  pready,
	input  wire logic [31:0]           prdata,
	input  wire logic                  pslverr,
	output logic                       psel,
	output logic                       penable,
	output logic                       pwrite,
	output logic      [AWG_APB_AW-1:0] paddr,
	output logic      [31:0]           pwdata
);
	initial
	begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// Wait for pready; only the bench watchdog ends a hang
		do
			@(posedge clock);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

/* File: dv/atomic_write_guard_and_pi_decode_test.sv */
// Testbench for the atomic write guard
`timescale 1ns/1ps
module atomic_write_guard_and_pi_decode_test;
	import awg_pkg::*;
	typedef struct packed {logic [63:0] s; logic [15:0] nlb; logic n; logic pf;} awg_row_t;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic clk_en = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, normal_atomic, powerfail_atomic, may_lose_data;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic er;
	awg_pi_dec_t pi_decode;
	int miscompares = 0;
	int tests_run = 0;
	// Config: units 8/4 blocks, sizes 16/8, offset 2
	awg_row_t rows [8] = '{'{64'h2, 16'h3, 1'b1, 1'b1}, '{64'h2, 16'h7, 1'b1, 1'b0},
		'{64'h8, 16'h3, 1'b1, 1'b0}, '{64'h10, 16'h3, 1'b0, 1'b0},
		'{64'h0, 16'h3, 1'b0, 1'b0}, '{64'h12, 16'h7, 1'b1, 1'b0},
		'{64'h1_0000_0000, 16'h1, 1'b1, 1'b1}, '{64'h11, 16'h1, 1'b0, 1'b0}};
	always #50 clock = ~clock;
	awg_host i_host (.clock, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
		.pwdata);
	awg_guard i_dut (.clock, .nrst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .normal_atomic, .powerfail_atomic, .may_lose_data,
		.pi_decode);
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, rd, er);
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		i_host.xfer(1'b0, a, 32'h0, rd, er);
		chk(nm, e, rd);
	endtask
	task cmd(input logic [63:0] s, input logic [31:0] c);
		wr(AWG_OFF_SLBA_LO, s[31:0]);
		wr(AWG_OFF_SLBA_HI, s[63:32]);
		wr(AWG_OFF_CMD, c | 32'h8000_0000);
		wt(4);
	endtask
	function automatic logic [6:0] pi_exp(logic f, logic b, logic w, logic [3:0] p);
		logic a;
		a = p[3];
		if (!f)
			return 7'h00;
		return {a & !b & !w, a & !b & w, a & b & w, !a | (b & !w), p[2:0]};
	endfunction
	initial
	begin
		wt(5000);
		miscompares++;
		$display("[ERR] watchdog expected finish seen timeout");
		give_verdict;
	end
	initial
	begin
		logic [3:0] p;
		wt(8);
		nrst <= 1'b1;
		wr(AWG_OFF_NS_AU, 32'h0003_0007);
		wr(AWG_OFF_BSIZE, 32'h0008_0010);
		wr(AWG_OFF_BOFF, 32'h2);
		foreach (rows[i])
		begin
			cmd(rows[i].s, {16'h0020, rows[i].nlb});
			chk("normal_atomic", {31'h0, rows[i].n}, {31'h0, normal_atomic});
			chk("powerfail_atomic", {31'h0, rows[i].pf}, {31'h0, powerfail_atomic});
		end
		rdc("status", AWG_OFF_STATUS, 32'h0000_0064);
		wr(AWG_OFF_BOFF, 32'h9);
		rdc("cfg_err", AWG_OFF_STATUS, 32'h0000_0264);
		$display("boundary table done");
		wr(AWG_OFF_BSIZE, 32'h0);
		rdc("bsize_zero", AWG_OFF_BSIZE, 32'h0);
		cmd(64'h0, 32'h0020_0003);
		chk("no_bound", 32'h3, {30'h0, normal_atomic, powerfail_atomic});
		wr(AWG_OFF_CTRL_AU, 32'h0001_0002);
		wr(AWG_OFF_CAU_CTRL_COMPARE_WRITE_ATOMIC_UNIT, 32'h3);
		rdc("ctrl_units", AWG_OFF_CTRL_AU, 32'h0);
		rdc("ctrl_cw_unit", AWG_OFF_CAU_CTRL_COMPARE_WRITE_ATOMIC_UNIT, 32'h0);
		wr(AWG_OFF_CTRL, 32'h1);
		wr(AWG_OFF_CTRL_AU, 32'h0001_0002);
		rdc("ctrl_units_xb", AWG_OFF_CTRL_AU, 32'h0001_0002);
		rdc("ctrl_cw_unit_xb", AWG_OFF_CAU_CTRL_COMPARE_WRITE_ATOMIC_UNIT, 32'h3);
		i_host.xfer(1'b0, 8'h40, 32'h0, rd, er);
		chk("unmapped_err", 32'h1, {31'h0, er});
		chk("unmapped_data", 32'h0, rd);
		$display("unit and map tests done");
		for (int k = 0; k < 16; k++)
		begin
			p = {k[3], k[2:0] ^ 3'h6};
			wr(AWG_OFF_CTRL, {27'h0, k[1], k[0], 3'h0});
			cmd(64'h0, {10'h0, k[2], 1'b0, p, 16'h0});
			chk("pi_decode", pi_exp(k[0], k[1], k[2], p), pi_decode);
			rdc("pi_reg", AWG_OFF_PI, {25'h0, pi_exp(k[0], k[1], k[2], p)});
		end
		$display("protection decode done");
		wr(AWG_OFF_CTRL, 32'h86);
		cmd(64'h0, 32'h0020_0000);
		chk("may_lose", 32'h1, {31'h0, may_lose_data});
		wr(AWG_OFF_CTRL, 32'hA6);
		wt(2);
		chk("may_lose_flush", 32'h0, {31'h0, may_lose_data});
		wr(AWG_OFF_CTRL, 32'h86);
		cmd(64'h0, 32'h0030_0000);
		chk("may_lose_fua", 32'h0, {31'h0, may_lose_data});
		rdc("cmd_echo", AWG_OFF_CMD, 32'h0030_0000);
		$display("cache loss done");
		// Frozen clock enable must drop the write
		clk_en <= 1'b0;
		wr(AWG_OFF_CTRL, 32'h1);
		clk_en <= 1'b1;
		rdc("ctrl_frozen", AWG_OFF_CTRL, 32'h86);
		nrst <= 1'b0;
		wt(3);
		nrst <= 1'b1;
		wt(1);
		chk("reset_out", 32'h0, {normal_atomic, powerfail_atomic, may_lose_data, pi_decode});
		rdc("reset_ctrl", AWG_OFF_CTRL, 32'h0);
		$display("freeze and reset done");
		give_verdict;
	end
endmodule
